// File: cwc_pkg.sv
package cwc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int SUM_W  = 16;
  localparam int MADR_W = 12;

  // ----------------------------------------------------------------
  // Address map of the programming access port
  // ----------------------------------------------------------------
  localparam logic [13:0] ADDR_PROG_LAST = 14'h0FFF;
  localparam logic [13:0] ADDR_DATA_LAST = 14'h00FF;
  localparam logic [13:0] ADDR_ID_FIRST  = 14'h2000;
  localparam logic [13:0] ADDR_ID_LAST   = 14'h2003;
  localparam logic [13:0] ADDR_OPT_A     = 14'h2007;
  localparam logic [13:0] ADDR_OPT_B     = 14'h2008;

  // ----------------------------------------------------------------
  // Reset values and checksum masks
  // ----------------------------------------------------------------
  localparam logic [13:0] OPT_A_RESET    = 14'h3FFF;
  localparam logic [13:0] OPT_B_RESET    = 14'h3FFF;
  localparam logic [13:0] ID_RESET       = 14'h3FFF;
  localparam logic [13:0] OPT_A_SUM_MASK = 14'h3FFF;
  localparam logic [13:0] OPT_B_SUM_MASK = 14'h0003;
  localparam logic [13:0] OPT_B_UNIMPL   = 14'h3FFC;
  localparam logic [3:0]  ID_NIB_MASK    = 4'hF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPT_A_CP_BIT     = 13;
  localparam int OPT_A_CPD_BIT    = 8;
  localparam int OPT_A_LVE_BIT    = 7;
  localparam int OPT_A_BOD_BIT    = 6;
  localparam int OPT_A_RPF_BIT    = 5;
  localparam int OPT_A_OSC_HI_BIT = 4;
  localparam int OPT_A_PUD_BIT    = 3;
  localparam int OPT_A_WDT_BIT    = 2;
  localparam int OPT_B_SWO_BIT    = 1;
  localparam int OPT_B_FCM_BIT    = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_LP            = 3'h0,
    OSC_XT            = 3'h1,
    OSC_HS            = 3'h2,
    OSC_EXT_CLOCK     = 3'h3,
    OSC_INT_RC_IO     = 3'h4,
    OSC_INT_RC_CLKOUT = 3'h5,
    OSC_EXT_RC_IO     = 3'h6,
    OSC_EXT_RC_CLKOUT = 3'h7
  } cwc_osc_t;

  typedef struct packed {
    logic     code_protect_n;
    logic     data_memory_protect_n;
    logic     low_voltage_entry_enable;
    logic     brownout_detect_enable;
    logic     reset_pin_function_select;
    logic     powerup_delay_enable_n;
    logic     watchdog_enable;
    cwc_osc_t oscillator_select;
    logic     clkout_enable;
    logic     clock_switchover_enable;
    logic     failsafe_clock_monitor_enable;
  } cwc_options_t;

  typedef struct packed {
    logic        write;
    logic        data_space;
    logic [13:0] addr;
    logic [13:0] wdata;
  } cwc_access_t;

endpackage

// File: cwc_sum_accum.sv
`timescale 1ns/1ps
module cwc_sum_accum
  import cwc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  // Accumulate control
  input  wire logic             clear_in,
  input  wire logic             add_in,
  input  wire logic [SUM_W-1:0] word_in,
  // Running total
  output logic      [SUM_W-1:0] sum_out
);

  logic [SUM_W-1:0] sum_q;
  logic [SUM_W-1:0] sum_d;

  // ----------------------------------------------------------------
  // Sixteen-bit wrap: carries out of the top bit are dropped
  // ----------------------------------------------------------------
  assign sum_d = clear_in ? '0 : (add_in ? sum_q + word_in : sum_q);

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      sum_q <= '0;
    else
      sum_q <= sum_d;
  end

  assign sum_out = sum_q;

endmodule // cwc_sum_accum

// File: cwc_option_core.sv
`timescale 1ns/1ps
module cwc_option_core
  import cwc_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  // Programming access port
  input  wire logic              access_valid_in,
  input  wire cwc_access_t       access_req_in,
  output logic      [WORD_W-1:0] access_rdata_out,
  output logic                   access_rvalid_out,
  output logic                   access_refused_out,
  // Memory array port
  output logic      [MADR_W-1:0] mem_addr_out,
  output logic                   mem_data_space_out,
  output logic                   mem_re_out,
  output logic                   mem_we_out,
  output logic      [WORD_W-1:0] mem_wdata_out,
  input  wire logic [WORD_W-1:0] mem_rdata_in,
  // Checksum engine
  input  wire logic              sum_start_in,
  output logic                   sum_busy_out,
  output logic                   sum_valid_out,
  output logic      [SUM_W-1:0]  sum_value_out,
  // Shared pins
  input  wire logic              port_b_pin_3_in,
  input  wire logic              shared_reset_pin_in,
  output logic                   low_voltage_entry_input_out,
  output logic                   port_b_pin_3_gpio_out,
  output logic                   reset_pin_gpio_out,
  output logic                   internal_reset_n_out,
  // Decoded options
  output cwc_options_t           options_out
);

  typedef enum logic [2:0] {CS_IDLE, CS_MEM, CS_DRAIN, CS_CFG_A, CS_CFG_B, CS_IDS} cwc_sum_state_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic in_mem_range(input cwc_access_t r);
    in_mem_range = r.data_space ? (r.addr <= ADDR_DATA_LAST) : (r.addr <= ADDR_PROG_LAST);
  endfunction

  function automatic logic is_protected(input logic dsp, input logic cp_n, input logic cpd_n);
    is_protected = dsp ? ~cpd_n : ~cp_n;
  endfunction

  function automatic logic has_clkout(input cwc_osc_t m);
    has_clkout = (m == OSC_EXT_RC_CLKOUT) || (m == OSC_INT_RC_CLKOUT);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] opt_a_q;
  logic [1:0]        opt_b_q;
  logic [WORD_W-1:0] id_q [4];
  logic [1:0]        sync1_q;
  logic [1:0]        sync2_q;
  cwc_options_t      opts_d;
  cwc_options_t      opts_q;
  logic              lve_in_q;
  logic              pin3_gpio_q;
  logic              rpin_gpio_q;
  logic              int_rst_n_q;
  cwc_sum_state_t    state_q;
  cwc_sum_state_t    state_d;
  logic [MADR_W-1:0] sum_addr_q;
  logic              mem_pend_q;
  logic              sum_valid_q;
  logic              rd_pend_q;
  logic              rd_mem_q;
  logic              rd_blank_q;
  logic [WORD_W-1:0] rd_local_q;
  logic [WORD_W-1:0] rdata_q;
  logic              rvalid_q;
  logic              busy;
  logic              take;
  logic              hit_mem;
  logic              hit_id;
  logic              hit_opt_a;
  logic              hit_opt_b;
  logic              prot_hit;
  logic              wr_mem;
  logic              wr_refused;
  logic [1:0]        id_sel;
  logic [WORD_W-1:0] opt_b_read;
  logic [WORD_W-1:0] local_rdata;
  logic [SUM_W-1:0]  packed_identifier_value;
  logic [SUM_W-1:0]  add_word;
  logic              add_en;
  logic              sum_clear;
  logic [SUM_W-1:0]  sum_total;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign busy       = (state_q != CS_IDLE);
  assign take       = access_valid_in & ~busy & ~sum_start_in;
  assign hit_mem    = in_mem_range(access_req_in);
  assign hit_id     = ~access_req_in.data_space & (access_req_in.addr >= ADDR_ID_FIRST)
                      & (access_req_in.addr <= ADDR_ID_LAST);
  assign hit_opt_a  = ~access_req_in.data_space & (access_req_in.addr == ADDR_OPT_A);
  assign hit_opt_b  = ~access_req_in.data_space & (access_req_in.addr == ADDR_OPT_B);
  assign prot_hit   = hit_mem & is_protected(access_req_in.data_space, opt_a_q[OPT_A_CP_BIT],
                                             opt_a_q[OPT_A_CPD_BIT]);
  assign wr_mem     = take & access_req_in.write & hit_mem & ~prot_hit;
  assign wr_refused = take & access_req_in.write & prot_hit;
  assign id_sel     = access_req_in.addr[1:0];
  assign opt_b_read = OPT_B_UNIMPL | {12'h000, opt_b_q};
  // Option words and identifiers ignore protection on read
  assign local_rdata = hit_opt_a ? opt_a_q :
                       hit_opt_b ? opt_b_read :
                       hit_id    ? id_q[id_sel] : '0;

  // Refusal is a pulse in the request cycle; a busy engine also refuses
  assign access_refused_out = (access_valid_in & (busy | sum_start_in)) | wr_refused;

  // ----------------------------------------------------------------
  // Memory port: engine owns it in CS_MEM, else the access port
  // ----------------------------------------------------------------
  assign mem_addr_out       = (state_q == CS_MEM) ? sum_addr_q : access_req_in.addr[MADR_W-1:0];
  assign mem_data_space_out = (state_q == CS_MEM) ? 1'b0 : access_req_in.data_space;
  assign mem_re_out         = (state_q == CS_MEM) | (take & ~access_req_in.write & hit_mem & ~prot_hit);
  assign mem_we_out         = wr_mem;
  assign mem_wdata_out      = access_req_in.wdata;

  // ----------------------------------------------------------------
  // Option word and identifier storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      opt_a_q <= OPT_A_RESET;
      opt_b_q <= OPT_B_RESET[1:0];
      for (int i = 0; i < 4; i++)
        id_q[i] <= ID_RESET;
    end
    else if (take & access_req_in.write)
    begin
      // Protection never blocks these, so a locked part can still be reconfigured
      if (hit_opt_a)
        opt_a_q <= access_req_in.wdata;
      if (hit_opt_b)
        opt_b_q <= access_req_in.wdata[1:0];
      if (hit_id)
        id_q[id_sel] <= access_req_in.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read pipeline: answer two edges after the request
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rd_pend_q  <= 1'b0;
      rd_mem_q   <= 1'b0;
      rd_blank_q <= 1'b0;
      rd_local_q <= '0;
      rdata_q    <= '0;
      rvalid_q   <= 1'b0;
    end
    else
    begin
      rd_pend_q  <= take & ~access_req_in.write;
      rd_mem_q   <= hit_mem;
      rd_blank_q <= prot_hit;
      rd_local_q <= local_rdata;
      rvalid_q   <= rd_pend_q;
      if (rd_pend_q)
        rdata_q <= rd_mem_q ? (rd_blank_q ? '0 : mem_rdata_in) : rd_local_q;
    end
  end

  assign access_rdata_out  = rdata_q;
  assign access_rvalid_out = rvalid_q;

  // ----------------------------------------------------------------
  // Option decode
  // ----------------------------------------------------------------
  always_comb
  begin
    opts_d                               = '0;
    opts_d.code_protect_n                = opt_a_q[OPT_A_CP_BIT];
    opts_d.data_memory_protect_n         = opt_a_q[OPT_A_CPD_BIT];
    opts_d.low_voltage_entry_enable      = opt_a_q[OPT_A_LVE_BIT];
    opts_d.brownout_detect_enable        = opt_a_q[OPT_A_BOD_BIT];
    opts_d.reset_pin_function_select     = opt_a_q[OPT_A_RPF_BIT];
    opts_d.powerup_delay_enable_n        = opt_a_q[OPT_A_PUD_BIT];
    opts_d.watchdog_enable               = opt_a_q[OPT_A_WDT_BIT];
    opts_d.oscillator_select             = cwc_osc_t'({opt_a_q[OPT_A_OSC_HI_BIT], opt_a_q[1:0]});
    opts_d.clkout_enable                 = has_clkout(opts_d.oscillator_select);
    opts_d.clock_switchover_enable       = opt_b_q[OPT_B_SWO_BIT];
    opts_d.failsafe_clock_monitor_enable = opt_b_q[OPT_B_FCM_BIT];
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and pin function
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      opts_q      <= '0;
      lve_in_q    <= 1'b0;
      pin3_gpio_q <= 1'b0;
      rpin_gpio_q <= 1'b0;
      int_rst_n_q <= 1'b0;
    end
    else
    begin
      sync1_q     <= {shared_reset_pin_in, port_b_pin_3_in};
      sync2_q     <= sync1_q;
      opts_q      <= opts_d;
      lve_in_q    <= opts_q.low_voltage_entry_enable & sync2_q[0];
      pin3_gpio_q <= ~opts_q.low_voltage_entry_enable;
      rpin_gpio_q <= ~opts_q.reset_pin_function_select;
      // Tied inactive when the pin is I/O, so pin toggling cannot reset the core
      int_rst_n_q <= opts_q.reset_pin_function_select ? sync2_q[1] : 1'b1;
    end
  end

  assign options_out                 = opts_q;
  assign low_voltage_entry_input_out = lve_in_q;
  assign port_b_pin_3_gpio_out       = pin3_gpio_q;
  assign reset_pin_gpio_out          = rpin_gpio_q;
  assign internal_reset_n_out        = int_rst_n_q;

  // ----------------------------------------------------------------
  // Checksum sequencer
  // ----------------------------------------------------------------
  assign packed_identifier_value = {id_q[0][3:0] & ID_NIB_MASK, id_q[1][3:0] & ID_NIB_MASK,
                                    id_q[2][3:0] & ID_NIB_MASK, id_q[3][3:0] & ID_NIB_MASK};

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CS_IDLE:  if (sum_start_in) state_d = opt_a_q[OPT_A_CP_BIT] ? CS_MEM : CS_CFG_A;
      CS_MEM:   if (sum_addr_q == ADDR_PROG_LAST[MADR_W-1:0]) state_d = CS_DRAIN;
      CS_DRAIN: state_d = CS_CFG_A;
      CS_CFG_A: state_d = CS_CFG_B;
      CS_CFG_B: state_d = opt_a_q[OPT_A_CP_BIT] ? CS_IDLE : CS_IDS;
      CS_IDS:   state_d = CS_IDLE;
    endcase
  end

  // Memory words land one edge after their address, hence the drain step
  assign add_word = mem_pend_q             ? {2'b00, mem_rdata_in} :
                    (state_q == CS_CFG_A)  ? {2'b00, opt_a_q & OPT_A_SUM_MASK} :
                    (state_q == CS_CFG_B)  ? {2'b00, opt_b_read & OPT_B_SUM_MASK} :
                    packed_identifier_value;
  assign add_en    = mem_pend_q | (state_q == CS_CFG_A) | (state_q == CS_CFG_B) | (state_q == CS_IDS);
  assign sum_clear = (state_q == CS_IDLE) & sum_start_in;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q     <= CS_IDLE;
      sum_addr_q  <= '0;
      mem_pend_q  <= 1'b0;
      sum_valid_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      mem_pend_q <= (state_q == CS_MEM);
      sum_addr_q <= (state_q == CS_MEM) ? sum_addr_q + 1'b1 : '0;
      if (sum_clear)
        sum_valid_q <= 1'b0;
      else if (busy & (state_d == CS_IDLE))
        sum_valid_q <= 1'b1;
    end
  end

  cwc_sum_accum u_sum_accum (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (sum_clear),
    .add_in     (add_en),
    .word_in    (add_word),
    .sum_out    (sum_total)
  );

  assign sum_busy_out  = busy;
  assign sum_valid_out = sum_valid_q;
  assign sum_value_out = sum_total;

endmodule // cwc_option_core

// File: cwc_option_core_asserts.sv
`timescale 1ns/1ps
module cwc_option_core_asserts
  import cwc_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk_in,
  input wire logic              rst_n_in,
  // Access port
  input wire logic              access_valid_in,
  input wire cwc_access_t       access_req_in,
  input wire logic [WORD_W-1:0] access_rdata_out,
  input wire logic              access_rvalid_out,
  input wire logic              access_refused_out,
  input wire logic              mem_we_out,
  // Checksum engine
  input wire logic              sum_start_in,
  input wire logic              sum_busy_out,
  input wire logic              sum_valid_out,
  input wire logic [SUM_W-1:0]  sum_value_out,
  // Pins and options
  input wire logic              low_voltage_entry_input_out,
  input wire logic              port_b_pin_3_gpio_out,
  input wire logic              reset_pin_gpio_out,
  input wire logic              internal_reset_n_out,
  input wire cwc_options_t      options_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Options lag storage by one cycle, so skip the cycle after a write
  logic wr_q;
  wire  acc_w  = access_valid_in && !sum_busy_out && !sum_start_in;
  wire  rd_w   = acc_w && !access_req_in.write;
  wire  prog_w = !access_req_in.data_space && (access_req_in.addr <= ADDR_PROG_LAST);
  wire  prot_w = !options_out.code_protect_n && !wr_q;
  wire  go_w   = sum_start_in && !sum_busy_out;
  always_ff @(posedge ref_clk_in)
    wr_q <= !rst_n_in || (acc_w && access_req_in.write);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_lat; rd_w |-> ##2 access_rvalid_out; endproperty
  property p_optb_ones; rd_w && !access_req_in.data_space && access_req_in.addr == ADDR_OPT_B
    |-> ##2 access_rdata_out[13:2] == 12'hFFF;
  endproperty
  property p_prot_rd; rd_w && prog_w && prot_w |-> ##2 access_rdata_out == 14'h0000; endproperty
  property p_prot_wr; acc_w && access_req_in.write && prog_w && prot_w |-> access_refused_out && !mem_we_out;
  endproperty
  property p_pin3; $past(rst_n_in) |-> port_b_pin_3_gpio_out == !$past(options_out.low_voltage_entry_enable);
  endproperty
  property p_lve_off; $past(rst_n_in) && !$past(options_out.low_voltage_entry_enable)
    |-> !low_voltage_entry_input_out; endproperty
  property p_rpin; $past(rst_n_in) |-> reset_pin_gpio_out == !$past(options_out.reset_pin_function_select);
  endproperty
  property p_intrst; $past(rst_n_in) && !$past(options_out.reset_pin_function_select)
    |-> internal_reset_n_out; endproperty
  property p_sum_clr; go_w |=> !sum_valid_out && sum_value_out == 16'h0000; endproperty
  property p_cp_sum; go_w && prot_w |-> ##1 sum_busy_out [*3] ##1 sum_valid_out; endproperty
  a_rd_lat:    assert property (p_rd_lat)    else $error("read answer not two cycles after request");
  a_optb_ones: assert property (p_optb_ones) else $error("option B upper bits not all ones");
  a_prot_rd:   assert property (p_prot_rd)   else $error("protected program read not zero");
  a_prot_wr:   assert property (p_prot_wr)   else $error("protected program write not refused");
  a_pin3:      assert property (p_pin3)      else $error("pin 3 mode does not follow entry bit");
  a_lve_off:   assert property (p_lve_off)   else $error("entry input active with entry bit clear");
  a_rpin:      assert property (p_rpin)      else $error("reset pin mode does not follow function bit");
  a_intrst:    assert property (p_intrst)    else $error("internal reset not held inactive");
  a_sum_clr:   assert property (p_sum_clr)   else $error("checksum not cleared at start");
  a_cp_sum:    assert property (p_cp_sum)    else $error("protected checksum length wrong");
  c_cp_sum:    cover property (go_w && prot_w);
  c_prot_wr:   cover property (access_refused_out);
  c_opt_b:     cover property (rd_w && access_req_in.addr == ADDR_OPT_B);
endmodule // cwc_option_core_asserts

bind cwc_option_core cwc_option_core_asserts i_cwc_option_core_asserts (
  .ref_clk_in, .rst_n_in, .access_valid_in, .access_req_in, .access_rdata_out, .access_rvalid_out,
  .access_refused_out, .mem_we_out, .sum_start_in, .sum_busy_out, .sum_valid_out, .sum_value_out,
  .low_voltage_entry_input_out, .port_b_pin_3_gpio_out, .reset_pin_gpio_out, .internal_reset_n_out,
  .options_out);

// File: cwc_mem_model.sv
`timescale 1ns/1ps
module cwc_mem_model
  import cwc_pkg::*;
(
  // Clock
  input  wire logic              ref_clk_in,
  // Memory array port
  input  wire logic              mem_re_in,
  input  wire logic              mem_we_in,
  input  wire logic              mem_data_space_in,
  input  wire logic [MADR_W-1:0] mem_addr_in,
  input  wire logic [WORD_W-1:0] mem_wdata_in,
  output logic      [WORD_W-1:0] mem_rdata_out
);
  // ----------------------------------------------------------------
  // Arrays
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] prog [4096];
  logic [WORD_W-1:0] dmem [256];
  initial
  begin
    for (int i = 0; i < 4096; i++)
      prog[i] = 14'(i) * 14'h0AB5 + 14'h01F3;
    for (int i = 0; i < 256; i++)
      dmem[i] = 14'h3FFF;
    mem_rdata_out = 14'h0000;
  end
  // Data is valid only in the cycle after a read; otherwise the line toggles
  always @(posedge ref_clk_in)
  begin
    if (mem_re_in)
      mem_rdata_out <= mem_data_space_in ? dmem[mem_addr_in[7:0]] : prog[mem_addr_in];
    else
      mem_rdata_out <= ~mem_rdata_out;
    if (mem_we_in && mem_data_space_in)
      dmem[mem_addr_in[7:0]] <= mem_wdata_in;
    else if (mem_we_in)
      prog[mem_addr_in] <= mem_wdata_in;
  end
endmodule // cwc_mem_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import cwc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              ref_clk_in, rst_n_in, access_valid_in, access_rvalid_out, access_refused_out;
  cwc_access_t       access_req_in;
  logic [WORD_W-1:0] access_rdata_out, mem_wdata_out, mem_rdata_in, rd;
  logic [MADR_W-1:0] mem_addr_out;
  logic              mem_data_space_out, mem_re_out, mem_we_out, rf;
  logic              sum_start_in, sum_busy_out, sum_valid_out;
  logic [SUM_W-1:0]  sum_value_out, exp_sum;
  logic              port_b_pin_3_in, shared_reset_pin_in, low_voltage_entry_input_out;
  logic              port_b_pin_3_gpio_out, reset_pin_gpio_out, internal_reset_n_out;
  cwc_options_t      options_out;
  int                err_count, total_checks;

  cwc_option_core i_cwc_option_core (.ref_clk_in, .rst_n_in, .access_valid_in, .access_req_in,
    .access_rdata_out, .access_rvalid_out, .access_refused_out, .mem_addr_out, .mem_data_space_out,
    .mem_re_out, .mem_we_out, .mem_wdata_out, .mem_rdata_in, .sum_start_in, .sum_busy_out, .sum_valid_out,
    .sum_value_out, .port_b_pin_3_in, .shared_reset_pin_in, .low_voltage_entry_input_out,
    .port_b_pin_3_gpio_out, .reset_pin_gpio_out, .internal_reset_n_out, .options_out);
  cwc_mem_model i_cwc_mem_model (.ref_clk_in, .mem_re_in(mem_re_out), .mem_we_in(mem_we_out),
    .mem_data_space_in(mem_data_space_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .mem_rdata_out(mem_rdata_in));

  always #2 ref_clk_in = ~ref_clk_in;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // One request; reads answer exactly two cycles after the request cycle
  task automatic acc(input logic wr, input logic ds, input logic [13:0] a, input logic [13:0] d);
    @(posedge ref_clk_in);
    access_valid_in <= 1'b1;
    access_req_in   <= '{wr, ds, a, d};
    #1 rf = access_refused_out;
    @(posedge ref_clk_in);
    access_valid_in <= 1'b0;
    if (!wr)
    begin
      // The answer stands for one cycle only, between the first and second edge after the taking edge
      wt(1);
      chk(16'(access_rvalid_out), 16'h0001);
      rd = access_rdata_out;
    end
  endtask

  task automatic run_sum();
    int k = 0;
    @(posedge ref_clk_in);
    sum_start_in <= 1'b1;
    @(posedge ref_clk_in);
    sum_start_in <= 1'b0;
    do wt(1); while (sum_valid_out !== 1'b1 && ++k < 5000);
    if (k >= 5000)
      err_count++;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_in = 0;
    rst_n_in = 0;
    access_valid_in = 0;
    access_req_in = '0;
    sum_start_in = 0;
    port_b_pin_3_in = 0;
    shared_reset_pin_in = 1;
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    acc(0, 0, ADDR_OPT_A, 14'h0000);
    chk(16'(rd), 16'h3FFF);
    acc(0, 0, ADDR_OPT_B, 14'h0000);
    chk(16'(rd), 16'h3FFF);
    for (int i = 0; i < 4; i++)
    begin
      acc(1, 0, ADDR_OPT_B, 14'(i));
      acc(0, 0, ADDR_OPT_B, 14'h0000);
      chk(16'(rd), 16'h3FFC | 16'(i));
      chk(16'(options_out.clock_switchover_enable), 16'(i[1]));
      chk(16'(options_out.failsafe_clock_monitor_enable), 16'(i[0]));
    end
    for (int i = 0; i < 8; i++)
    begin
      acc(1, 0, ADDR_OPT_A, 14'h3FEC | (14'(i[2]) << 4) | 14'(i[1:0]));
      wt(2);
      chk(16'(options_out.oscillator_select), 16'(i));
      chk(16'(options_out.clkout_enable), 16'(i == 5 || i == 7));
    end
    // Pins: entry input high, reset pin low; clear entry, brown-out, reset pin, delay bits
    @(posedge ref_clk_in);
    port_b_pin_3_in <= 1'b1;
    shared_reset_pin_in <= 1'b0;
    acc(1, 0, ADDR_OPT_A, 14'h3F17);
    wt(6);
    chk(16'(options_out.low_voltage_entry_enable), 16'h0000);
    chk({14'h0000, low_voltage_entry_input_out, port_b_pin_3_gpio_out}, 16'h0001);
    chk({14'h0000, reset_pin_gpio_out, internal_reset_n_out}, 16'h0003);
    chk(16'(options_out.brownout_detect_enable), 16'h0000);
    chk(16'(options_out.powerup_delay_enable_n), 16'h0000);
    acc(1, 0, ADDR_OPT_A, 14'h3FFF);
    wt(6);
    chk({14'h0000, low_voltage_entry_input_out, port_b_pin_3_gpio_out}, 16'h0002);
    chk({14'h0000, reset_pin_gpio_out, internal_reset_n_out}, 16'h0000);
    chk(16'(options_out.brownout_detect_enable), 16'h0001);
    chk(16'(options_out.powerup_delay_enable_n), 16'h0001);
    // Unprotected checksum over the whole array, with carries dropped
    acc(1, 0, 14'h0010, 14'h3FF0);
    chk(16'(rf), 16'h0000);
    acc(0, 0, 14'h0010, 14'h0000);
    chk(16'(rd), 16'h3FF0);
    exp_sum = 16'h3FFF + 16'h0003;
    for (int i = 0; i < 4096; i++)
      exp_sum += 16'(i_cwc_mem_model.prog[i]);
    run_sum();
    chk(sum_value_out, exp_sum);
    // Data protection
    acc(1, 1, 14'h0005, 14'h0ABC);
    acc(0, 1, 14'h0005, 14'h0000);
    chk(16'(rd), 16'h0ABC);
    acc(1, 0, ADDR_OPT_A, 14'h3EFF);
    wt(2);
    chk(16'(options_out.data_memory_protect_n), 16'h0000);
    acc(0, 1, 14'h0005, 14'h0000);
    chk(16'(rd), 16'h0000);
    acc(1, 1, 14'h0005, 14'h0123);
    chk(16'(rf), 16'h0001);
    chk(16'(i_cwc_mem_model.dmem[5]), 16'h0ABC);
    // Code protection with identifiers
    for (int i = 0; i < 4; i++)
      acc(1, 0, ADDR_ID_FIRST + 14'(i), 14'h3FF0 | 14'(i + 1));
    acc(1, 0, ADDR_OPT_A, 14'h1FFF);
    wt(2);
    chk(16'(options_out.code_protect_n), 16'h0000);
    acc(0, 0, ADDR_ID_FIRST, 14'h0000);
    chk(16'(rd), 16'h3FF1);
    acc(0, 0, ADDR_OPT_A, 14'h0000);
    chk(16'(rd), 16'h1FFF);
    acc(0, 0, 14'h0010, 14'h0000);
    chk(16'(rd), 16'h0000);
    acc(1, 0, 14'h0010, 14'h0005);
    chk(16'(rf), 16'h0001);
    chk(16'(i_cwc_mem_model.prog[16]), 16'h3FF0);
    run_sum();
    chk(sum_value_out, 16'h1FFF + 16'h0003 + 16'h1234);
    close_out();
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk_in);
    err_count++;
    close_out();
  end
endmodule // testbench
